// ---- common/fsfab_pkg.sv ----
// How it works
// - Seven 4-bit optimal size exponents, upper reserved
// - Scale factor is integer 256 times ratio
// - Progress counted in thousandths of a percent, full is 100000
// - Full progress increments total cycle count
// - Full progress stops refresh, progress to zero
// - Selective method still advances full step
// - Init flag: host sets, reads one while running
// - Lasting write protect written only once
// - Boot-time protect cleared only by power-on
// - Housekeeping permitted only while flag set
// - Device clears refresh enable; host may abort
// - Removal flag: host sets, device clears
// - Busy flag mirrors time-related internal work
// - Firmware lock written once, blocks updates
// - Boot select codes zero, one, two only
// - Power mode codes, active after reset
// - Current cap accepts zero to 0Fh
// - Housekeeping need level codes zero to three
// - Secure erase state codes zero to five
// - Reference clock codes zero to three, default 26MHz
// - Terminal refresh state clears after first read
package fsfab_pkg;

   // ****************************************
   // Address spaces and indices
   // ****************************************
   localparam logic [1:0] SP_FLAG   = 2'h0;
   localparam logic [1:0] SP_ATTR   = 2'h1;
   localparam logic [1:0] SP_HEALTH = 2'h2;

   localparam logic [5:0] F_INIT    = 6'h01;
   localparam logic [5:0] F_LWP     = 6'h02;
   localparam logic [5:0] F_BWP     = 6'h03;
   localparam logic [5:0] F_HKEEP   = 6'h04;
   localparam logic [5:0] F_LIFE    = 6'h05;
   localparam logic [5:0] F_ERASE   = 6'h06;
   localparam logic [5:0] F_REWR    = 6'h07;
   localparam logic [5:0] F_REMOVE  = 6'h08;
   localparam logic [5:0] F_TBUSY   = 6'h09;
   localparam logic [5:0] F_FWLOCK  = 6'h0b;

   localparam logic [5:0] A_BOOT    = 6'h00;
   localparam logic [5:0] A_PMODE   = 6'h02;
   localparam logic [5:0] A_ICC     = 6'h03;
   localparam logic [5:0] A_UNORD   = 6'h04;
   localparam logic [5:0] A_HNEED   = 6'h05;
   localparam logic [5:0] A_ESTATE  = 6'h06;
   localparam logic [5:0] A_INCHUNK = 6'h07;
   localparam logic [5:0] A_OUTCHNK = 6'h08;
   localparam logic [5:0] A_CAPREQ  = 6'h09;
   localparam logic [5:0] A_REFCLK  = 6'h0a;
   localparam logic [5:0] A_FREEZE  = 6'h0b;
   localparam logic [5:0] A_RTT     = 6'h0c;
   localparam logic [5:0] A_EXCMASK = 6'h0d;
   localparam logic [5:0] A_EXCPEND = 6'h0e;
   localparam logic [5:0] A_SECONDS = 6'h0f;

   localparam logic [5:0] H_EXPON   = 6'h00;
   localparam logic [5:0] H_SCALE0  = 6'h01;
   localparam logic [5:0] H_SCALE5  = 6'h06;
   localparam logic [5:0] H_TOTAL   = 6'h07;
   localparam logic [5:0] H_PROG    = 6'h08;
   localparam logic [5:0] H_STEP    = 6'h09;
   localparam logic [5:0] H_METHOD  = 6'h0a;
   localparam logic [5:0] H_RSTATE  = 6'h0b;

   // ****************************************
   // Reset values and codes
   // ****************************************
   localparam logic [7:0] RST_PMODE  = 8'h11;
   localparam logic [7:0] RST_CHUNK  = 8'h40;
   localparam logic [7:0] RST_REFCLK = 8'h01;
   localparam logic [7:0] RST_RTT    = 8'h02;
   localparam logic [7:0] MAX_BOOT   = 8'h02;
   localparam logic [7:0] MAX_ICC    = 8'h0f;
   localparam logic [7:0] MAX_REFCLK = 8'h03;
   localparam logic [7:0] STEP_FULL  = 8'h01;
   localparam logic [7:0] METH_SEL   = 8'h02;
   localparam logic [7:0] NEED_CRIT  = 8'h03;
   localparam logic [31:0] PROG_FULL = 32'h000186a0;
   localparam int unsigned SCALE_ONE = 256;

   typedef enum logic [7:0] {
      FSFAB_RW_IDLE  = 8'h00,
      FSFAB_RW_BUSY  = 8'h01,
      FSFAB_RW_STOP  = 8'h02,
      FSFAB_RW_DONE  = 8'h03,
      FSFAB_RW_QFAIL = 8'h04,
      FSFAB_RW_FAIL  = 8'h05
   } fsfab_rw_t;

endpackage : fsfab_pkg

// ---- src/fsfab_top.sv ----
module fsfab_top #(
   parameter logic [27:0] BEST_EXPONENTS = 28'h0000000,
   parameter int unsigned CAP_NORMAL     = 1024,
   parameter int unsigned CAP_TYPE [6]   = '{1024, 1024, 1024,
                                             341, 1024, 1024},
   parameter logic [31:0] MIN_STEP       = 32'h000003e8
) (
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire logic        ce,
   input  wire logic        ep_reset,
   input  wire logic [7:0]  addr,
   input  wire logic [31:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic      [31:0] rdata,
   input  wire logic        init_done,
   input  wire logic        queues_busy,
   input  wire logic        unit_done,
   input  wire logic        rewrite_error,
   input  wire logic        capacity_work_done,
   input  wire logic        time_work_busy,
   input  wire logic        pool_exhausted,
   input  wire logic        pmode_load,
   input  wire logic [7:0]  pmode_in,
   input  wire logic [1:0]  need_level_in,
   input  wire logic [2:0]  erase_state_in,
   input  wire logic [31:0] capacity_needed_in,
   output logic             init_run,
   output logic             rewrite_run,
   output logic             housekeeping_run,
   output logic             secure_erase_run,
   output logic             write_protect,
   output logic             firmware_locked,
   output logic             capacity_work_start,
   output logic             exception_alert,
   output logic [7:0]       boot_unit_select,
   output logic [7:0]       active_current_cap,
   output logic [7:0]       ref_clock_select
);
   import fsfab_pkg::*;

   // ****************************************
   // Decode
   // ****************************************
   function automatic logic hit(input logic [7:0] a,
                                input logic [1:0] sp,
                                input logic [5:0] ix);
      hit = (a[7:6] == sp) && (a[5:0] == ix);
   endfunction : hit

   function automatic logic [15:0] scale(input int unsigned t);
      longint unsigned q;
      q = (longint'(CAP_NORMAL) * SCALE_ONE) / longint'(t);
      scale = q[15:0];
   endfunction : scale

   wire        wbit   = wdata[0];
   wire [7:0]  wbyte  = wdata[7:0];
   wire        w_init = wr && hit(addr, SP_FLAG, F_INIT);
   wire        w_lwp  = wr && hit(addr, SP_FLAG, F_LWP);
   wire        w_bwp  = wr && hit(addr, SP_FLAG, F_BWP);
   wire        w_hk   = wr && hit(addr, SP_FLAG, F_HKEEP);
   wire        w_life = wr && hit(addr, SP_FLAG, F_LIFE);
   wire        w_ers  = wr && hit(addr, SP_FLAG, F_ERASE);
   wire        w_rewr = wr && hit(addr, SP_FLAG, F_REWR);
   wire        w_rem  = wr && hit(addr, SP_FLAG, F_REMOVE);
   wire        w_fw   = wr && hit(addr, SP_FLAG, F_FWLOCK);
   wire        w_boot = wr && hit(addr, SP_ATTR, A_BOOT);
   wire        w_icc  = wr && hit(addr, SP_ATTR, A_ICC);
   wire        w_unrd = wr && hit(addr, SP_ATTR, A_UNORD);
   wire        w_inch = wr && hit(addr, SP_ATTR, A_INCHUNK);
   wire        w_otch = wr && hit(addr, SP_ATTR, A_OUTCHNK);
   wire        w_rclk = wr && hit(addr, SP_ATTR, A_REFCLK);
   wire        w_frz  = wr && hit(addr, SP_ATTR, A_FREEZE);
   wire        w_rtt  = wr && hit(addr, SP_ATTR, A_RTT);
   wire        w_mask = wr && hit(addr, SP_ATTR, A_EXCMASK);
   wire        w_secs = wr && hit(addr, SP_ATTR, A_SECONDS);
   wire        w_step = wr && hit(addr, SP_HEALTH, H_STEP);
   wire        w_meth = wr && hit(addr, SP_HEALTH, H_METHOD);
   wire        r_rst  = rd && hit(addr, SP_HEALTH, H_RSTATE);

   // ****************************************
   // Flags
   // ****************************************
   logic        init_flag, lwp_flag, lwp_used, bwp_flag, hk_flag;
   logic        life_flag, erase_flag, rewr_flag, remove_flag;
   logic        fw_flag, fw_used, unord_used, frz_used;
   logic [7:0]  unord, freeze, in_chunk, out_chunk, rtt;
   logic [7:0]  pmode, step_amt, method;
   logic [15:0] exc_mask;
   logic [31:0] seconds, progress, total, next_progress, next_total;
   fsfab_rw_t   rw_state, next_rw_state;
   logic        dev_clr_rewr;

   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         init_flag   <= 1'b0;
         lwp_flag    <= 1'b0;
         lwp_used    <= 1'b0;
         bwp_flag    <= 1'b0;
         fw_flag     <= 1'b0;
         fw_used     <= 1'b0;
         remove_flag <= 1'b0;
      end
      else if (ce)
      begin
         if (w_init && wbit)
            init_flag <= 1'b1;
         else if (init_done)
            init_flag <= 1'b0;
         if (w_lwp && !lwp_used)
         begin
            lwp_flag <= wbit;
            lwp_used <= 1'b1;
         end
         if (w_bwp && wbit)
            bwp_flag <= 1'b1;
         if (w_fw && !fw_used)
         begin
            fw_flag <= wbit;
            fw_used <= 1'b1;
         end
         if (w_rem && wbit)
            remove_flag <= 1'b1;
         else if (capacity_work_done)
            remove_flag <= 1'b0;
      end
   end

   // Volatile state also returns to defaults on endpoint reset
   always_ff @(posedge clk)
   begin
      if (!resetn || (ce && ep_reset))
      begin
         hk_flag    <= 1'b1;
         life_flag  <= 1'b0;
         erase_flag <= 1'b0;
         rewr_flag  <= 1'b0;
         active_current_cap <= 8'h00;
         exc_mask   <= 16'h0000;
      end
      else if (ce)
      begin
         if (w_hk)
            hk_flag <= wbit;
         if (w_life)
            life_flag <= wbit;
         if (w_ers)
            erase_flag <= wbit;
         if (w_rewr && wbit)
            rewr_flag <= 1'b1;
         else if ((w_rewr && !wbit) || dev_clr_rewr)
            rewr_flag <= 1'b0;
         if (w_icc && wbyte <= MAX_ICC)
            active_current_cap <= wbyte;
         if (w_mask)
            exc_mask <= {13'h0000, wdata[2:0]};
      end
   end

   // ****************************************
   // Attributes
   // ****************************************
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         boot_unit_select <= 8'h00;
         ref_clock_select <= RST_REFCLK;
         unord      <= 8'h00;
         unord_used <= 1'b0;
         freeze     <= 8'h00;
         frz_used   <= 1'b0;
         in_chunk   <= RST_CHUNK;
         out_chunk  <= RST_CHUNK;
         rtt        <= RST_RTT;
         pmode      <= RST_PMODE;
         seconds    <= 32'h00000000;
         step_amt   <= 8'h00;
         method     <= 8'h00;
      end
      else if (ce)
      begin
         if (w_boot && wbyte <= MAX_BOOT)
            boot_unit_select <= wbyte;
         if (w_rclk && wbyte <= MAX_REFCLK)
            ref_clock_select <= wbyte;
         if (w_unrd && !unord_used)
         begin
            unord      <= wbyte;
            unord_used <= 1'b1;
         end
         if (w_frz && !frz_used)
         begin
            freeze   <= wbyte;
            frz_used <= 1'b1;
         end
         if (w_inch)
            in_chunk <= wbyte;
         if (w_otch)
            out_chunk <= wbyte;
         if (w_rtt)
            rtt <= wbyte;
         if (pmode_load)
            pmode <= pmode_in;
         if (w_secs)
            seconds <= wdata;
         if (w_step)
            step_amt <= wbyte;
         if (w_meth)
            method <= wbyte;
      end
   end

   // ****************************************
   // Refresh engine
   // ****************************************
   // Same step whatever the method
   wire [31:0] step_cnt = (step_amt == STEP_FULL) ? PROG_FULL : MIN_STEP;
   wire [31:0] prog_sum = progress + step_cnt;
   wire        prog_wrap = prog_sum >= PROG_FULL;

   always_comb
   begin
      next_rw_state = rw_state;
      next_progress = progress;
      next_total    = total;
      dev_clr_rewr  = 1'b0;
      case (rw_state)
         FSFAB_RW_IDLE:
            if (rewr_flag)
            begin
               // Start refused while any queue holds work
               if (queues_busy)
               begin
                  next_rw_state = FSFAB_RW_QFAIL;
                  dev_clr_rewr  = 1'b1;
               end
               else
                  next_rw_state = FSFAB_RW_BUSY;
            end
         FSFAB_RW_BUSY:
            if (rewrite_error)
            begin
               next_rw_state = FSFAB_RW_FAIL;
               dev_clr_rewr  = 1'b1;
            end
            else if (!rewr_flag)
               next_rw_state = FSFAB_RW_STOP;
            else if (unit_done)
            begin
               next_rw_state = FSFAB_RW_DONE;
               dev_clr_rewr  = 1'b1;
               if (prog_wrap)
               begin
                  next_progress = 32'h00000000;
                  next_total    = total + 32'h00000001;
               end
               else
                  next_progress = prog_sum;
            end
         FSFAB_RW_STOP, FSFAB_RW_DONE, FSFAB_RW_QFAIL, FSFAB_RW_FAIL:
            if (r_rst)
               next_rw_state = FSFAB_RW_IDLE;
         default:
            next_rw_state = FSFAB_RW_IDLE;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         rw_state <= FSFAB_RW_IDLE;
         progress <= 32'h00000000;
         total    <= 32'h00000000;
      end
      else if (ce)
      begin
         rw_state <= next_rw_state;
         progress <= next_progress;
         total    <= next_total;
      end
   end

   // ****************************************
   // Status and read back
   // ****************************************
   // Pending bits from device events
   wire [15:0] exc_pend = {13'h0000, need_level_in == 2'h3,
                           pool_exhausted, capacity_needed_in != 32'h0};
   logic [31:0] rsel;

   always_comb
   begin
      rsel = 32'h00000000;
      case (addr[7:6])
         SP_FLAG:
            case (addr[5:0])
               F_INIT:   rsel[0] = init_flag;
               F_LWP:    rsel[0] = lwp_flag;
               F_BWP:    rsel[0] = bwp_flag;
               F_HKEEP:  rsel[0] = hk_flag;
               F_LIFE:   rsel[0] = life_flag;
               F_REMOVE: rsel[0] = remove_flag;
               F_TBUSY:  rsel[0] = time_work_busy;
               F_FWLOCK: rsel[0] = fw_flag;
               default:  rsel = 32'h00000000;
            endcase
         SP_ATTR:
            case (addr[5:0])
               A_BOOT:    rsel[7:0] = boot_unit_select;
               A_PMODE:   rsel[7:0] = pmode;
               A_ICC:     rsel[7:0] = active_current_cap;
               A_UNORD:   rsel[7:0] = unord;
               A_HNEED:   rsel[7:0] = {6'h00, need_level_in};
               A_ESTATE:  rsel[7:0] = {5'h00, erase_state_in};
               A_INCHUNK: rsel[7:0] = in_chunk;
               A_OUTCHNK: rsel[7:0] = out_chunk;
               A_CAPREQ:  rsel = capacity_needed_in;
               A_REFCLK:  rsel[7:0] = ref_clock_select;
               A_FREEZE:  rsel[7:0] = freeze;
               A_RTT:     rsel[7:0] = rtt;
               A_EXCMASK: rsel[15:0] = exc_mask;
               A_EXCPEND: rsel[15:0] = exc_pend;
               default:   rsel = 32'h00000000;
            endcase
         SP_HEALTH:
            if (addr[5:0] == H_EXPON)
               rsel = {4'h0, BEST_EXPONENTS};
            else if (addr[5:0] >= H_SCALE0 && addr[5:0] <= H_SCALE5)
               rsel[15:0] = scale(CAP_TYPE[3'(addr[5:0] - H_SCALE0)]);
            else if (addr[5:0] == H_TOTAL)
               rsel = total;
            else if (addr[5:0] == H_PROG)
               rsel = progress;
            else if (addr[5:0] == H_STEP)
               rsel[7:0] = step_amt;
            else if (addr[5:0] == H_METHOD)
               rsel[7:0] = method;
            else if (addr[5:0] == H_RSTATE)
               rsel[7:0] = rw_state;
         default:
            rsel = 32'h00000000;
      endcase
   end

   // Data stands only in the cycle after the read strobe
   always_ff @(posedge clk)
   begin
      if (!resetn)
         rdata <= 32'h00000000;
      else if (ce)
         rdata <= rd ? rsel : 32'h00000000;
   end

   assign init_run            = init_flag;
   assign rewrite_run         = rw_state == FSFAB_RW_BUSY;
   assign housekeeping_run    = hk_flag && (need_level_in != 2'h0);
   assign secure_erase_run    = erase_flag;
   assign write_protect       = lwp_flag || bwp_flag;
   assign firmware_locked     = fw_flag;
   assign capacity_work_start = ce && ep_reset && remove_flag;
   assign exception_alert     = |(exc_pend & exc_mask);

   // ****************************************
   // Checks
   // ****************************************
   sequence s_wrap_step;
      ce && rw_state == FSFAB_RW_BUSY && rewr_flag && !rewrite_error
         && unit_done && prog_wrap;
   endsequence
   sequence s_wrapped;
      progress == 32'h0 && total == $past(total) + 32'h1;
   endsequence

   a_refresh_wrap: assert property (
      @(posedge clk) disable iff (!resetn)
      s_wrap_step |=> s_wrapped)
      else $error("Full progress did not wrap and count");
   a_wrap_stops: assert property (
      @(posedge clk) disable iff (!resetn)
      s_wrap_step ##0 !(w_rewr && wbit)
      |=> !rewr_flag && rw_state == FSFAB_RW_DONE)
      else $error("Refresh kept running after full progress");
   a_terminal_read: assert property (
      @(posedge clk) disable iff (!resetn)
      ce && r_rst && rw_state inside {FSFAB_RW_STOP, FSFAB_RW_DONE,
         FSFAB_RW_QFAIL, FSFAB_RW_FAIL} |=> rw_state == FSFAB_RW_IDLE)
      else $error("Terminal refresh state not cleared by read");
   a_error_clears: assert property (
      @(posedge clk) disable iff (!resetn)
      ce && rw_state == FSFAB_RW_BUSY && rewrite_error && !w_rewr
      |=> !rewr_flag && rw_state == FSFAB_RW_FAIL)
      else $error("Refresh error did not clear enable");
   // Sampled reset keeps a short power-on pulse out of these checks
   a_lwp_once: assert property (
      @(posedge clk) disable iff (!resetn)
      resetn && lwp_used |=> $stable(lwp_flag))
      else $error("Lasting protect changed after first write");
   a_fw_once: assert property (
      @(posedge clk) disable iff (!resetn)
      resetn && fw_used |=> $stable(fw_flag))
      else $error("Firmware lock changed after first write");
   a_pmode_reset: assert property (
      @(posedge clk) !resetn |=> pmode == RST_PMODE)
      else $error("Power mode not active after reset");
   a_boot_codes: assert property (
      @(posedge clk) disable iff (!resetn) boot_unit_select <= MAX_BOOT)
      else $error("Reserved boot code stored");
   a_permit_gate: assert property (
      @(posedge clk) disable iff (!resetn)
      ce && w_hk && !wbit && !ep_reset |=> !housekeeping_run)
      else $error("Housekeeping ran without permit");
   a_bwp_sticky: assert property (
      @(posedge clk) disable iff (!resetn)
      resetn && bwp_flag |=> bwp_flag)
      else $error("Boot-time protect cleared without power-on");

endmodule : fsfab_top

// ---- tb/fsfab_host.sv ----
module fsfab_host (
   input  wire logic        clk,
   input  wire logic [31:0] rdata,
   output logic      [7:0]  addr,
   output logic      [31:0] wdata,
   output logic             wr,
   output logic             rd
);
   timeunit 1ns;
   timeprecision 1ps;
   // ********
   // Query master
   // ********
   initial
   begin
      {wr, rd} = 2'h0;
      addr     = 8'h00;
      wdata    = 32'h0;
   end
   task automatic put(input logic [7:0] a, input logic [31:0] d);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
      addr  <= ~a;
      wdata <= ~d;
      @(posedge clk);
   endtask : put
   // Released lines show garbage, never the last value
   task automatic get(input logic [7:0] a, output logic [31:0] d);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      addr <= ~a;
      @(posedge clk);
      d = rdata;
   endtask : get
endmodule : fsfab_host

// ---- tb/fsfab_tb_top.sv ----
module fsfab_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   // ********
   // Signals and tables
   // ********
   logic        clk, resetn, ce, ep_reset, wr, rd, init_done, queues_busy;
   logic        unit_done, rewrite_error, capacity_work_done;
   logic        time_work_busy, pool_exhausted, pmode_load, init_run;
   logic        rewrite_run, housekeeping_run, secure_erase_run;
   logic        write_protect, firmware_locked, capacity_work_start;
   logic        exception_alert;
   logic [1:0]  need_level_in;
   logic [2:0]  erase_state_in;
   logic [7:0]  addr, pmode_in, boot_unit_select, active_current_cap;
   logic [7:0]  ref_clock_select;
   logic [31:0] wdata, rdata, capacity_needed_in;
   int          n_errors = 0;
   int          checked = 0;
   localparam int unsigned CAP [6] = '{600, 512, 300, 1024, 341, 2048};
   localparam logic [15:0] LIM [3] = '{16'h4002, 16'h430f, 16'h4a03};
   localparam logic [7:0]  PM [7] = '{8'h00, 8'h10, 8'h11, 8'h20,
                                      8'h22, 8'h30, 8'h33};
   localparam logic [39:0] ROWS [28] = '{
      {8'h01, 32'h0}, {8'h02, 32'h0}, {8'h03, 32'h0}, {8'h04, 32'h1},
      {8'h05, 32'h0}, {8'h06, 32'h0}, {8'h07, 32'h0}, {8'h08, 32'h0},
      {8'h09, 32'h0}, {8'h0a, 32'h0}, {8'h0b, 32'h0}, {8'h0f, 32'h0},
      {8'h40, 32'h0}, {8'h41, 32'h0}, {8'h42, 32'h11}, {8'h43, 32'h0},
      {8'h44, 32'h0}, {8'h47, 32'h40}, {8'h48, 32'h40}, {8'h4a, 32'h1},
      {8'h4b, 32'h0}, {8'h4c, 32'h2}, {8'h4d, 32'h0}, {8'h4f, 32'h0},
      {8'h80, 32'h07654321}, {8'h87, 32'h0}, {8'h88, 32'h0},
      {8'hc0, 32'h0}};

   fsfab_top #(.BEST_EXPONENTS(28'h7654321), .CAP_NORMAL(1024),
               .CAP_TYPE(CAP), .MIN_STEP(32'h0000c350)) fsfab_top_i (
      .clk, .resetn, .ce, .ep_reset, .addr, .wdata, .wr, .rd, .rdata,
      .init_done, .queues_busy, .unit_done, .rewrite_error,
      .capacity_work_done, .time_work_busy, .pool_exhausted, .pmode_load,
      .pmode_in, .need_level_in, .erase_state_in, .capacity_needed_in,
      .init_run, .rewrite_run, .housekeeping_run, .secure_erase_run,
      .write_protect, .firmware_locked, .capacity_work_start,
      .exception_alert, .boot_unit_select, .active_current_cap,
      .ref_clock_select);
   fsfab_host fsfab_host_i (.clk, .rdata, .addr, .wdata, .wr, .rd);

   // ********
   // Checking tasks
   // ********
   task automatic chk(input logic [31:0] s, e, input string n);
      checked++;
      if (s !== e)
      begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      fsfab_host_i.get(a, d);
      chk(d, e, $sformatf("reg %h", a));
   endtask : rdc
   task automatic report_and_stop;
      $display("checks %0d errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : report_and_stop
   // each start after the first follows a state read that left it idle
   task automatic refresh(input logic [1:0] how, input logic [31:0] es);
      fsfab_host_i.put(8'h07, 32'h1);
      repeat (2) @(posedge clk);
      chk(32'(rewrite_run), 32'(how != 2'd3), "rewrite_run");
      if (how == 2'd1)
         fsfab_host_i.put(8'h07, 32'h0);
      unit_done     <= (how == 2'd0);
      rewrite_error <= (how == 2'd2);
      @(posedge clk);
      unit_done     <= 1'b0;
      rewrite_error <= 1'b0;
      repeat (2) @(posedge clk);
      rdc(8'h8b, es);
      rdc(8'h8b, 32'h0);
      $display("test refresh %0d done", how);
   endtask : refresh

   // ********
   // Clock, watchdog, sequence
   // ********
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   initial
   begin
      repeat (5000) @(posedge clk);
      n_errors++;
      report_and_stop();
   end
   initial
   begin
      {resetn, ep_reset, init_done, queues_busy, unit_done} = 5'h0;
      {rewrite_error, capacity_work_done, time_work_busy} = 3'h0;
      {pool_exhausted, pmode_load, pmode_in} = 10'h0;
      {need_level_in, erase_state_in, capacity_needed_in} = 37'h0;
      ce = 1'b1;
      repeat (8) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      for (int i = 0; i < 28; i++)
         rdc(ROWS[i][39:32], ROWS[i][31:0]);
      for (int i = 1; i < 7; i++)
         rdc(8'h80 + i[7:0], 32'(1024 * 256 / CAP[i-1]));
      $display("test reset values done");
      for (int i = 0; i < 3; i++)
         for (int j = 0; j <= LIM[i][7:0] + 1; j++)
         begin
            fsfab_host_i.put(LIM[i][15:8], 32'(j));
            rdc(LIM[i][15:8], 32'(j > LIM[i][7:0] ? LIM[i][7:0] : j));
         end
      chk({24'h0, boot_unit_select}, 32'h2, "boot");
      chk({24'h0, active_current_cap}, 32'hf, "cap");
      chk({24'h0, ref_clock_select}, 32'h3, "refclk");
      foreach (PM[i])
      begin
         pmode_in   <= PM[i];
         pmode_load <= 1'b1;
         @(posedge clk);
         pmode_load <= 1'b0;
         rdc(8'h42, {24'h0, PM[i]});
      end
      for (int i = 0; i < 6; i++)
      begin
         need_level_in  <= 2'(i);
         erase_state_in <= 3'(i);
         @(posedge clk);
         rdc(8'h45, 32'(i % 4));
         rdc(8'h46, 32'(i));
         chk(32'(housekeeping_run), 32'(i % 4 != 0), "hk_run");
      end
      fsfab_host_i.put(8'h04, 32'h0);
      chk(32'(housekeeping_run), 32'h0, "hk_run");
      $display("test codes done");
      capacity_needed_in <= 32'h10;
      fsfab_host_i.put(8'h4d, 32'h6);
      chk(32'(exception_alert), 32'h0, "alert");
      fsfab_host_i.put(8'h4d, 32'h1);
      chk(32'(exception_alert), 32'h1, "alert");
      pool_exhausted <= 1'b1;
      need_level_in  <= 2'h3;
      rdc(8'h4e, 32'h7);
      $display("test exceptions done");
      fsfab_host_i.put(8'h01, 32'h1);
      chk(32'(init_run), 32'h1, "init_run");
      init_done <= 1'b1;
      @(posedge clk);
      init_done <= 1'b0;
      rdc(8'h01, 32'h0);
      fsfab_host_i.put(8'h02, 32'h1);
      fsfab_host_i.put(8'h02, 32'h0);
      rdc(8'h02, 32'h1);
      fsfab_host_i.put(8'h0b, 32'h1);
      fsfab_host_i.put(8'h0b, 32'h0);
      rdc(8'h0b, 32'h1);
      chk(32'(firmware_locked & write_protect), 32'h1, "locks");
      fsfab_host_i.put(8'h03, 32'h1);
      fsfab_host_i.put(8'h08, 32'h1);
      fsfab_host_i.put(8'h08, 32'h0);
      fsfab_host_i.put(8'h06, 32'h1);
      chk(32'(secure_erase_run), 32'h1, "erase_run");
      rdc(8'h06, 32'h0);
      fsfab_host_i.put(8'h44, 32'h1);
      fsfab_host_i.put(8'h44, 32'h0);
      rdc(8'h44, 32'h1);
      time_work_busy <= 1'b1;
      ep_reset       <= 1'b1;
      #1;
      chk(32'(capacity_work_start), 32'h1, "cap_start");
      @(posedge clk);
      ep_reset <= 1'b0;
      rdc(8'h03, 32'h1);
      rdc(8'h04, 32'h1);
      rdc(8'h08, 32'h1);
      rdc(8'h09, 32'h1);
      chk(32'(secure_erase_run), 32'h0, "erase_run");
      chk({24'h0, active_current_cap}, 32'h0, "cap");
      capacity_work_done <= 1'b1;
      @(posedge clk);
      capacity_work_done <= 1'b0;
      rdc(8'h08, 32'h0);
      $display("test flags done");
      fsfab_host_i.put(8'h8a, 32'h2);
      refresh(2'd0, 32'h3);
      rdc(8'h88, 32'hc350);
      refresh(2'd0, 32'h3);
      rdc(8'h88, 32'h0);
      rdc(8'h87, 32'h1);
      fsfab_host_i.put(8'h89, 32'h1);
      refresh(2'd0, 32'h3);
      rdc(8'h87, 32'h2);
      refresh(2'd1, 32'h2);
      refresh(2'd2, 32'h5);
      queues_busy <= 1'b1;
      refresh(2'd3, 32'h4);
      resetn <= 1'b0;
      @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      rdc(8'h03, 32'h0);
      rdc(8'h42, 32'h11);
      $display("test power-on reset done");
      report_and_stop();
   end
endmodule : fsfab_tb_top
